//--- lsem_clk_loss.sv
`timescale 1ns/100ps
`include "lsem_defs.svh"

module lsem_clk_loss #(
  parameter int unsigned LOSS_CYC = `LSEM_TX_LOSS_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  // line clock level, already synchronised
  input  wire logic line_clk_in,
  // loss indication
  output logic      loss_out
);

  localparam logic [7:0] LOSS_C = 8'(LOSS_CYC);

  logic       prev_q;
  logic       prev_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       loss_q;
  logic       loss_d;

  // ****************************************************************
  // idle counter
  // ****************************************************************
  always_comb begin
    prev_d = line_clk_in;
    cnt_d  = cnt_q;
    if (line_clk_in != prev_q) begin
      cnt_d = '0;
    end else if (cnt_q <= LOSS_C) begin
      // saturates one above the limit so it never wraps
      cnt_d = cnt_q + 1'b1;
    end
    loss_d = (cnt_d > LOSS_C);
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      prev_q <= 1'b0;
      cnt_q  <= 8'h00;
      loss_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
      loss_q <= loss_d;
    end
  end

  assign loss_out = loss_q;

endmodule

//--- lsem_defs.svh
`ifndef LSEM_DEFS_SVH
`define LSEM_DEFS_SVH

// ****************************************************************
// clock and timing
// ****************************************************************
`define LSEM_CLK_HZ          10000000
`define LSEM_QUAL_SHORT_MS   40
`define LSEM_QUAL_LONG_S     5.1
`define LSEM_TX_LOSS_CYCLES  70
`define LSEM_QUAL_CW         26

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define LSEM_IDX_MASK   6'h14
`define LSEM_IDX_EDGE   6'h16
`define LSEM_IDX_LIVE   6'h17
`define LSEM_IDX_EVENT  6'h19
`define LSEM_IDX_CLEAR  6'h1A
`define LSEM_IDX_CTRL   6'h1B

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define LSEM_NUM_FLAGS      5
`define LSEM_FLAG_LSB       3
`define LSEM_FLAG_EQ        4
`define LSEM_FLAG_UP        3
`define LSEM_FLAG_DN        2
`define LSEM_FLAG_PAT       1
`define LSEM_FLAG_TCL       0
`define LSEM_MASK_RST       5'h1F
`define LSEM_EDGE_RST       5'h00
`define LSEM_FLAGS_RST      5'h00
`define LSEM_CTRL_AUTO_BIT  0
`define LSEM_CTRL_RLP_BIT   1

`endif

//--- lsem_line_status_event_monitor.sv
// Function
// - live status register is read-only and shows present conditions, not history
// - equalizer range flag reads 1 when out of range, 0 in range
// - loop-up flag sets after activate code held error-free beyond qualification time
// - a set loop-up flag stays while error rate holds, clears otherwise
// - qualification time is 40 ms, or 5.1 s when auto loop switch on
// - loop-up flag rising edge starts remote loopback when auto switching enabled
// - loop-down flag qualifies like loop-up flag, using the deactivate code
// - loop-down flag rising edge ends remote loopback
// - pattern sync flag shows live test pattern lock
// - tx clock loss flag sets after over 70 cycles without a toggle
// - unmasked flag raises an event on rise, or any change if edge bit set
// - all five flags read 0 after reset
// - every interrupt mask is 1 after reset
`timescale 1ns/100ps
`include "lsem_defs.svh"

module lsem_line_status_event_monitor #(
  parameter int unsigned QUAL_SHORT_CYC = `LSEM_QUAL_SHORT_MS * (`LSEM_CLK_HZ / 1000),
  parameter int unsigned QUAL_LONG_CYC  = int'(`LSEM_QUAL_LONG_S * `LSEM_CLK_HZ),
  parameter int unsigned TX_LOSS_CYC    = `LSEM_TX_LOSS_CYCLES
) (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // line conditions from other domains
  input  wire logic        eq_out_of_range_in,
  input  wire logic        loop_up_code_seen_in,
  input  wire logic        loop_up_ber_ok_in,
  input  wire logic        loop_down_code_seen_in,
  input  wire logic        loop_down_ber_ok_in,
  input  wire logic        pattern_sync_in,
  input  wire logic        tx_line_clock_in,
  // results
  output logic             remote_loop_active_out,
  output logic             irq_out
);

  localparam int NF    = `LSEM_NUM_FLAGS;
  localparam int NSYNC = 7;

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync1_d;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] sync2_d;

  assign raw = {eq_out_of_range_in,
                loop_up_code_seen_in,
                loop_up_ber_ok_in,
                loop_down_code_seen_in,
                loop_down_ber_ok_in,
                pattern_sync_in,
                tx_line_clock_in};

  // the first stage feeds only the second, never any logic
  always_comb begin
    sync1_d = raw;
    sync2_d = sync1_q;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // ****************************************************************
  // condition detectors
  // ****************************************************************
  logic auto_q;
  logic auto_d;
  logic up_flag;
  logic dn_flag;
  logic tcl_flag;

  // both qualifiers follow the auto switch, so their times always stay paired
  lsem_loop_qual #(
    .CW        (`LSEM_QUAL_CW),
    .SHORT_CYC (QUAL_SHORT_CYC),
    .LONG_CYC  (QUAL_LONG_CYC)
  ) u_up_qual (
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .code_seen_in (sync2_q[5]),
    .ber_ok_in    (sync2_q[4]),
    .long_sel_in  (auto_q),
    .flag_out     (up_flag)
  );

  lsem_loop_qual #(
    .CW        (`LSEM_QUAL_CW),
    .SHORT_CYC (QUAL_SHORT_CYC),
    .LONG_CYC  (QUAL_LONG_CYC)
  ) u_dn_qual (
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .code_seen_in (sync2_q[3]),
    .ber_ok_in    (sync2_q[2]),
    .long_sel_in  (auto_q),
    .flag_out     (dn_flag)
  );

  lsem_clk_loss #(
    .LOSS_CYC (TX_LOSS_CYC)
  ) u_tx_loss (
    .ref_clk_in  (ref_clk_in),
    .sys_rst_in  (sys_rst_in),
    .line_clk_in (sync2_q[0]),
    .loss_out    (tcl_flag)
  );

  // ****************************************************************
  // live flags and edges
  // ****************************************************************
  lsem_pkg::lsem_flags_type flags;
  lsem_pkg::lsem_flags_type prev_q;
  lsem_pkg::lsem_flags_type prev_d;
  lsem_pkg::lsem_flags_type mask_q;
  lsem_pkg::lsem_flags_type mask_d;
  lsem_pkg::lsem_flags_type edge_q;
  lsem_pkg::lsem_flags_type edge_d;
  lsem_pkg::lsem_flags_type event_q;
  lsem_pkg::lsem_flags_type event_d;
  lsem_pkg::lsem_flags_type evt;
  lsem_pkg::lsem_flags_type clr;

  // eq, pattern and tx loss sources are flip-flops; the loop flags are decoded from the qualifier state registers
  assign flags[`LSEM_FLAG_EQ]  = sync2_q[6];
  assign flags[`LSEM_FLAG_UP]  = up_flag;
  assign flags[`LSEM_FLAG_DN]  = dn_flag;
  assign flags[`LSEM_FLAG_PAT] = sync2_q[1];
  assign flags[`LSEM_FLAG_TCL] = tcl_flag;

  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_evt
      logic rise;
      logic fall;
      assign rise   = flags[g] & ~prev_q[g];
      assign fall   = ~flags[g] & prev_q[g];
      // a fall counts only where the edge-select bit asks for both edges
      assign evt[g] = ~mask_q[g] & (rise | (edge_q[g] & fall));
    end
  endgenerate

  // ****************************************************************
  // remote loopback
  // ****************************************************************
  logic rlp_q;
  logic rlp_d;
  logic up_rise;
  logic dn_rise;

  // edges, not levels: a loop flag that stays high never re-arms the loopback
  always_comb begin
    up_rise = flags[`LSEM_FLAG_UP] & ~prev_q[`LSEM_FLAG_UP];
    dn_rise = flags[`LSEM_FLAG_DN] & ~prev_q[`LSEM_FLAG_DN];
    rlp_d   = rlp_q;
    if (up_rise && auto_q) begin
      rlp_d = 1'b1;
    end
    // deactivate wins if both edges land together
    if (dn_rise) begin
      rlp_d = 1'b0;
    end
  end

  // ****************************************************************
  // avalon slave
  // ****************************************************************
  logic [5:0]  idx;
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] rd_word;
  logic        wr;
  logic        wr_mask;
  logic        wr_edge;
  logic        wr_ctrl;
  logic        wr_clear;
  logic        irq_q;
  logic        irq_d;

  // one wait cycle: data is loaded at the first edge, taken at the second
  always_comb begin
    idx     = avs_address_in[7:2];
    wait_d  = ~((avs_read_in | avs_write_in) & wait_q);
    // only byte lane 0 matters: every field sits in the low byte
    wr      = avs_write_in & ~wait_q & avs_byteenable_in[0];
    rdata_d = rdata_q;
    if (avs_read_in && wait_q) begin
      rdata_d = rd_word;
    end
  end

  // ****************************************************************
  // readback word
  // ****************************************************************
  // the live view is taken at the first edge, while waitrequest is high, so a read shows the
  // conditions of that cycle and never a latched copy
  always_comb begin
    unique case (idx)
      `LSEM_IDX_MASK:  rd_word = 32'(mask_q) << `LSEM_FLAG_LSB;
      `LSEM_IDX_EDGE:  rd_word = 32'(edge_q) << `LSEM_FLAG_LSB;
      `LSEM_IDX_LIVE:  rd_word = 32'(flags) << `LSEM_FLAG_LSB;
      `LSEM_IDX_EVENT: rd_word = 32'(event_q) << `LSEM_FLAG_LSB;
      `LSEM_IDX_CTRL:  rd_word = 32'({rlp_q, auto_q});
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  // a write lands only at the edge that completes it, so one access
  // updates a register once; the live register has no strobe at all
  always_comb begin
    wr_mask  = wr && (idx == `LSEM_IDX_MASK);
    wr_edge  = wr && (idx == `LSEM_IDX_EDGE);
    wr_ctrl  = wr && (idx == `LSEM_IDX_CTRL);
    wr_clear = wr && (idx == `LSEM_IDX_CLEAR);
  end

  // ****************************************************************
  // control registers and sticky events
  // ****************************************************************
  always_comb begin
    mask_d = mask_q;
    edge_d = edge_q;
    auto_d = auto_q;
    clr    = 5'h00;
    prev_d = flags;
    // a mask bit of 0 enables its event: the mask is the enable register
    if (wr_mask) begin
      mask_d = avs_writedata_in[`LSEM_FLAG_LSB +: NF];
    end
    if (wr_edge) begin
      edge_d = avs_writedata_in[`LSEM_FLAG_LSB +: NF];
    end
    // the loop status bit is read-only; only the switch bit is stored
    if (wr_ctrl) begin
      auto_d = avs_writedata_in[`LSEM_CTRL_AUTO_BIT];
    end
    if (wr_clear) begin
      clr = avs_writedata_in[`LSEM_FLAG_LSB +: NF];
    end
    // a new event outranks a clear in the same cycle
    event_d = (event_q & ~clr) | evt;
    irq_d   = |(event_d & ~mask_d);
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
      mask_q  <= `LSEM_MASK_RST;
      edge_q  <= `LSEM_EDGE_RST;
      auto_q  <= 1'b0;
      prev_q  <= `LSEM_FLAGS_RST;
      event_q <= 5'h00;
      rlp_q   <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
      mask_q  <= mask_d;
      edge_q  <= edge_d;
      auto_q  <= auto_d;
      prev_q  <= prev_d;
      event_q <= event_d;
      rlp_q   <= rlp_d;
      irq_q   <= irq_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // every output is a flip-flop, so nothing downstream sees decode glitches
  assign avs_readdata_out       = rdata_q;
  assign avs_waitrequest_out    = wait_q;
  assign remote_loop_active_out = rlp_q;
  assign irq_out                = irq_q;

endmodule

//--- lsem_line_status_event_monitor_props.sv
`timescale 1ns/100ps
`include "lsem_defs.svh"
// ****************************
// port checker
// ****************************
module lsem_line_status_event_monitor_props (
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  input wire logic [7:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        eq_out_of_range_in,
  input wire logic        loop_up_code_seen_in,
  input wire logic        loop_up_ber_ok_in,
  input wire logic        loop_down_code_seen_in,
  input wire logic        loop_down_ber_ok_in,
  input wire logic        pattern_sync_in,
  input wire logic        tx_line_clock_in,
  input wire logic        remote_loop_active_out,
  input wire logic        irq_out
);
  logic       mask_wr_q;
  logic       mask_wr_d;
  logic [7:0] still_q;
  logic [7:0] still_d;
  logic       tprev_q;

  // raw pin count; sync lag is covered by margins in the properties
  always_comb begin
    mask_wr_d = mask_wr_q | (avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0]
                & (avs_address_in[7:2] == `LSEM_IDX_MASK));
    still_d   = (tx_line_clock_in != tprev_q) ? 8'h00 : still_q + {7'h00, still_q != 8'hFF};
  end

  always_ff @(posedge ref_clk_in) begin
    tprev_q <= tx_line_clock_in;
    if (sys_rst_in) begin
      mask_wr_q <= 1'b0;
      still_q   <= 8'h00;
    end else begin
      mask_wr_q <= mask_wr_d;
      still_q   <= still_d;
    end
  end

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence live_rd;
    avs_read_in && avs_waitrequest_out && avs_address_in[7:2] == `LSEM_IDX_LIVE;
  endsequence
  sequence void_rd;
    avs_read_in && avs_waitrequest_out
      && !(avs_address_in[7:2] inside {`LSEM_IDX_MASK, `LSEM_IDX_EDGE, `LSEM_IDX_LIVE,
                                       `LSEM_IDX_EVENT, `LSEM_IDX_CTRL});
  endsequence

  a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_req_answered: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered next cycle");
  a_reset_idle: assert property (
    $fell(sys_rst_in) |-> !irq_out && avs_waitrequest_out && !remote_loop_active_out)
    else $error("outputs not idle after reset");
  a_eq_live: assert property (
    $stable(eq_out_of_range_in)[*4] ##0 live_rd
      |=> avs_readdata_out[7] == $past(eq_out_of_range_in))
    else $error("equalizer flag differs from input");
  a_pat_live: assert property (
    $stable(pattern_sync_in)[*4] ##0 live_rd |=> avs_readdata_out[4] == $past(pattern_sync_in))
    else $error("pattern flag differs from input");
  a_unmapped_zero: assert property (void_rd |=> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_tx_loss_live: assert property (
    live_rd ##0 (still_q >= 8'h50 || (still_q > 8'h05 && still_q < 8'h3C))
      |=> avs_readdata_out[3] == $past(still_q >= 8'h50))
    else $error("tx clock loss flag wrong");
  a_irq_masked: assert property (!mask_wr_q |-> !irq_out)
    else $error("irq while masks at reset value");
  a_loop_up_on: assert property (
    $rose(remote_loop_active_out)
      |-> $past(loop_up_code_seen_in, 4) && $past(loop_up_ber_ok_in, 4))
    else $error("remote loop on without loop-up code");
  a_loop_dn_off: assert property (
    $fell(remote_loop_active_out)
      |-> $past(loop_down_code_seen_in, 4) && $past(loop_down_ber_ok_in, 4))
    else $error("remote loop off without loop-down code");
endmodule

bind lsem_line_status_event_monitor lsem_line_status_event_monitor_props u_props (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .eq_out_of_range_in(eq_out_of_range_in),
  .loop_up_code_seen_in(loop_up_code_seen_in), .loop_up_ber_ok_in(loop_up_ber_ok_in),
  .loop_down_code_seen_in(loop_down_code_seen_in), .loop_down_ber_ok_in(loop_down_ber_ok_in),
  .pattern_sync_in(pattern_sync_in), .tx_line_clock_in(tx_line_clock_in),
  .remote_loop_active_out(remote_loop_active_out), .irq_out(irq_out)
);

//--- lsem_line_status_event_monitor_tb_top.sv
`timescale 1ns/100ps
`include "lsem_defs.svh"
module lsem_line_status_event_monitor_tb_top;
  localparam logic [7:0] MASK = {`LSEM_IDX_MASK, 2'b00};
  localparam logic [7:0] EDGE = {`LSEM_IDX_EDGE, 2'b00};
  localparam logic [7:0] LIVE = {`LSEM_IDX_LIVE, 2'b00};
  localparam logic [7:0] EVT  = {`LSEM_IDX_EVENT, 2'b00};
  localparam logic [7:0] CLR  = {`LSEM_IDX_CLEAR, 2'b00};
  localparam logic [7:0] CTRL = {`LSEM_IDX_CTRL, 2'b00};

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'hF;
  logic        eq = 1'b0;
  logic        up_c = 1'b0;
  logic        up_b = 1'b0;
  logic        dn_c = 1'b0;
  logic        dn_b = 1'b0;
  logic        pat = 1'b0;
  logic        tck = 1'b0;
  logic        tx_run = 1'b1;
  logic [31:0] rdata;
  logic        wreq;
  logic        rloop;
  logic        irq;
  logic [31:0] q;
  logic [31:0] r;
  int          fail_count = 0;
  int          num_checks = 0;

  always #50 clk = ~clk;

  // tx line clock toggles every cycle unless a loss is being staged
  always @(posedge clk) begin
    if (tx_run) begin
      tck <= ~tck;
    end
  end

  lsem_line_status_event_monitor #(.QUAL_SHORT_CYC(20), .QUAL_LONG_CYC(60)) DUT (
    .ref_clk_in(clk), .sys_rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .eq_out_of_range_in(eq),
    .loop_up_code_seen_in(up_c), .loop_up_ber_ok_in(up_b), .loop_down_code_seen_in(dn_c),
    .loop_down_ber_ok_in(dn_b), .pattern_sync_in(pat), .tx_line_clock_in(tck),
    .remote_loop_active_out(rloop), .irq_out(irq)
  );

  // ****************************
  // bus and check tasks
  // ****************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // waits one edge first so a release is never re-driven in the same step
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= a;
    rd    <= !w;
    wr    <= w;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      $display("[FAIL] bus waitrequest expected 0 seen 1");
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(nm, q, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [31:0] ev_exp(input logic [4:0] e, input logic rise);
    return rise ? 32'h90 : {24'h0, e[4], 2'h0, e[1], 4'h0};
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end

  // ****************************
  // main sequence
  // ****************************
  initial begin
    r = $urandom(32'h1EEECB74);
    cyc(6);
    rst <= 1'b0;
    cyc(4);
    rchk("mask", MASK, 32'hF8);
    rchk("edge", EDGE, 32'h0);
    rchk("live", LIVE, 32'h0);
    rchk("event", EVT, 32'h0);
    rchk("clear", CLR, 32'h0);
    rchk("ctrl", CTRL, 32'h0);
    rchk("unmapped", 8'hFC, 32'h0);
    bus(LIVE, 1'b1, 32'hFF);
    rchk("live ro", LIVE, 32'h0);
    be <= 4'hE;
    bus(MASK, 1'b1, 32'h0);
    be <= 4'hF;
    rchk("mask lane0 off", MASK, 32'hF8);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      eq  <= r[0];
      pat <= r[1];
      cyc(4);
      rchk("live rnd", LIVE, {24'h0, r[0], 2'h0, r[1], 4'h0});
      chk("irq masked", irq, 32'h0);
    end
    eq  <= 1'b0;
    pat <= 1'b0;
    cyc(5);
    rchk("no masked event", EVT, 32'h0);
    bus(MASK, 1'b1, 32'h0);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      bus(EDGE, 1'b1, {24'h0, r[4:0], 3'h0});
      eq  <= 1'b1;
      pat <= 1'b1;
      cyc(5);
      rchk("event rise", EVT, ev_exp(r[4:0], 1'b1));
      chk("irq rise", irq, 32'h1);
      bus(CLR, 1'b1, 32'hF8);
      cyc(1);
      chk("irq cleared", irq, 32'h0);
      eq  <= 1'b0;
      pat <= 1'b0;
      cyc(5);
      rchk("event fall", EVT, ev_exp(r[4:0], 1'b0));
      chk("irq fall", irq, {31'h0, |ev_exp(r[4:0], 1'b0)});
      bus(CLR, 1'b1, 32'hF8);
    end
    tx_run <= 1'b0;
    cyc(60);
    rchk("tx short stop", LIVE, 32'h0);
    cyc(20);
    rchk("tx lost", LIVE, 32'h8);
    rchk("tx event", EVT, 32'h8);
    tx_run <= 1'b1;
    cyc(6);
    rchk("tx back", LIVE, 32'h0);
    up_c <= 1'b1;
    up_b <= 1'b1;
    cyc(10);
    rchk("up early", LIVE, 32'h0);
    cyc(20);
    rchk("up short", LIVE, 32'h40);
    chk("no auto loop", rloop, 32'h0);
    up_b <= 1'b0;
    cyc(5);
    rchk("up errors", LIVE, 32'h0);
    bus(CTRL, 1'b1, 32'h1);
    up_b <= 1'b1;
    cyc(40);
    rchk("up long early", LIVE, 32'h0);
    cyc(30);
    rchk("up long", LIVE, 32'h40);
    chk("loop on", rloop, 32'h1);
    rchk("ctrl loop", CTRL, 32'h3);
    up_c <= 1'b0;
    dn_c <= 1'b1;
    dn_b <= 1'b1;
    cyc(70);
    rchk("down set", LIVE, 32'h60);
    chk("loop off", rloop, 32'h0);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    rchk("live rst", LIVE, 32'h0);
    rchk("event rst", EVT, 32'h0);
    rchk("mask rst", MASK, 32'hF8);
    rchk("ctrl rst", CTRL, 32'h0);
    chk("irq rst", irq, 32'h0);
    test_done();
  end
endmodule

//--- lsem_loop_qual.sv
`timescale 1ns/100ps
`include "lsem_defs.svh"

module lsem_loop_qual #(
  parameter int          CW        = `LSEM_QUAL_CW,
  parameter int unsigned SHORT_CYC = 400000,
  parameter int unsigned LONG_CYC  = 51000000
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  // code detector, already on ref_clk_in
  input  wire logic code_seen_in,
  input  wire logic ber_ok_in,
  input  wire logic long_sel_in,
  // qualified flag
  output logic      flag_out
);

  localparam logic [CW-1:0] SHORT_C = CW'(SHORT_CYC);
  localparam logic [CW-1:0] LONG_C  = CW'(LONG_CYC);

  lsem_pkg::lsem_qual_state_type state_q;
  lsem_pkg::lsem_qual_state_type state_d;
  logic [CW-1:0]                 cnt_q;
  logic [CW-1:0]                 cnt_d;
  logic [CW-1:0]                 limit;
  logic                          good;

  // ****************************************************************
  // qualification
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    good    = code_seen_in & ber_ok_in;
    // the limit follows the switch live; a change mid-count keeps the count
    limit   = long_sel_in ? LONG_C : SHORT_C;
    unique case (state_q)
      lsem_pkg::qual_hunt: begin
        cnt_d = '0;
        if (good) begin
          state_d = lsem_pkg::qual_count;
        end
      end
      lsem_pkg::qual_count: begin
        if (!good) begin
          state_d = lsem_pkg::qual_hunt;
        end else if (cnt_q >= limit) begin
          state_d = lsem_pkg::qual_held;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      lsem_pkg::qual_held: begin
        // only the error rate can drop a held flag
        if (!ber_ok_in) begin
          state_d = lsem_pkg::qual_hunt;
        end
      end
      default: begin
        state_d = lsem_pkg::qual_hunt;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_q <= lsem_pkg::qual_hunt;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign flag_out = (state_q == lsem_pkg::qual_held);

endmodule

//--- lsem_pkg.sv
package lsem_pkg;

  // loop code qualification progress
  typedef enum logic [2:0] {
    qual_hunt  = 3'h1,
    qual_count = 3'h2,
    qual_held  = 3'h4
  } lsem_qual_state_type;

  typedef logic [4:0] lsem_flags_type;

endpackage
